/* drcu_pkg.sv */
package drcu_pkg;

    // register offsets
    localparam logic [7:0]  OFF_BASE       = 8'he0;
    localparam logic [7:0]  OFF_INTERVAL   = 8'he2;
    localparam logic [7:0]  OFF_ENABLE_CNT = 8'he4;

    // widths
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 16;
    localparam int          CNT_W          = 9;
    localparam int          ROW_W          = 9;
    localparam int          BASE_W         = 7;
    localparam int          PHYS_W         = 20;
    localparam int          FIX_ZERO_W     = 3;

    // field positions
    localparam int          EN_BIT         = 15;
    localparam int          BASE_LSB       = 9;
    localparam int          BASE_MSB       = 15;
    localparam int          CNT_MSB        = 8;

    // row counter feedback taps and reset seed
    localparam int          LFSR_TAP_A     = 8;
    localparam int          LFSR_TAP_B     = 4;
    localparam logic [8:0]  ROW_SEED       = 9'h001;

    // reset values and fixed encodings
    localparam logic [8:0]  CNT_ZERO       = 9'h000;
    localparam logic [8:0]  CNT_ONE        = 9'h001;
    localparam logic [8:0]  CNT_DEC        = 9'h001;
    localparam logic [8:0]  INTERVAL_RST   = 9'h000;
    localparam logic [6:0]  BASE_RST       = 7'h00;
    localparam logic [15:0] RDATA_ZERO     = 16'h0000;
    localparam logic [2:0]  FIX_ZERO_BITS  = 3'h0;
    localparam logic        ADDR_A0_REFR   = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD,
        ST_RECLAIM,
        ST_RUN
    } drcu_state_e;

endpackage

/* drcu_row_if.sv */
`timescale 1ns/100ps
`default_nettype none

// row counter link between control and the feedback shift counter
interface drcu_row_if;
    logic                    step;
    logic [drcu_pkg::ROW_W-1:0] row;

    modport ctrl (output step, input row);
    modport ctr  (input step, output row);
endinterface

`default_nettype wire

/* drcu_row_lfsr.sv */
`timescale 1ns/100ps
`default_nettype none

module drcu_row_lfsr (
    // clock and reset
    input  wire logic   mclk_i,
    input  wire logic   sys_rst_i,
    // row counter link
    drcu_row_if.ctr     row_if
);
    import drcu_pkg::*;

    logic [ROW_W-1:0] row_reg;
    logic [ROW_W-1:0] row_next;

    // maximal-length shift sequence, never reaches all zeros
    always_comb begin
        row_next = row_reg;
        if (row_if.step) begin
            row_next = {row_reg[ROW_W-2:0], row_reg[LFSR_TAP_A] ^ row_reg[LFSR_TAP_B]};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            row_reg <= ROW_SEED;
        end else begin
            row_reg <= row_next;
        end
    end

    assign row_if.row = row_reg;

endmodule

`default_nettype wire

/* drcu_top.sv */
// Notes on behaviour
// - enable bit, bit 15 of enable/count register, switches the refresh unit on and off.
// - writes to enable/count register only change the enable bit.
// - clearing enable halts the down counter and forces it to zero.
// - reading enable/count returns enable plus live count; count zero when disabled.
// - writing enable/count while running leaves the live count untouched.
// - counter loads from interval when enabled from zero or on reaching 1.
// - once loaded, counter decrements every clock while enabled, regardless of bus.
// - count of 1 raises refresh request, held through the refresh cycle until it completes.
// - at count 1 counter reloads at once, not waiting for service.
// - completed refresh cycle clears the request and steps the row counter.
// - refresh is a memory read with A0 high; high byte or strobe marks it.
// - address is base bits, three zeros, row counter bits, then a 1.
// - row counter is a feedback shift counter, not a binary count.
// - hold grant stays asserted while hold request stays and no refresh pending.
// - pending refresh under hold drops hold grant to reclaim the bus.
// - a reclaimed refresh cycle starts only after the external master removes hold request.
// - hold request after refresh is granted once refresh completes, unless new request.
// - requests are not queued; address advances only on an actual refresh.
// - refresh request wins the bus over processor, DMA and hold requests.
// - registers respond only in enhanced mode; otherwise accesses are ignored.
`timescale 1ns/100ps
`default_nettype none

module drcu_top #(
    parameter bit BUS_16 = 1'b1
) (
    // clock and reset
    input  wire logic                         mclk_i,
    input  wire logic                         sys_rst_i,
    // register port
    input  wire logic [drcu_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [drcu_pkg::DATA_W-1:0]  reg_wdata_i,
    input  wire logic                         reg_wr_i,
    input  wire logic                         reg_rd_i,
    output logic      [drcu_pkg::DATA_W-1:0]  reg_rdata_o,
    input  wire logic                         enhanced_mode_i,
    // bus interface unit side
    output logic                              refresh_req_o,
    output logic                              refresh_cycle_o,
    input  wire logic                         refresh_done_i,
    output logic      [drcu_pkg::PHYS_W-1:0]  refresh_addr_o,
    output logic                              high_byte_enable_o,
    output logic                              refresh_strobe_n_o,
    // arbitration with other masters
    input  wire logic                         other_req_i,
    output logic                              other_grant_o,
    input  wire logic                         hold_req_i,
    output logic                              bus_hold_grant_o
);
    import drcu_pkg::*;

    // register state
    logic                  enable_reg;
    logic [CNT_W-1:0]      live_count_reg;
    logic [CNT_W-1:0]      live_count_next;
    logic [CNT_W-1:0]      interval_count_reg;
    logic [BASE_W-1:0]     base_address_reg;
    logic [DATA_W-1:0]     rdata_reg;
    logic [DATA_W-1:0]     rdata_next;

    // request and arbitration state
    logic                  pending_reg;
    logic                  tick;
    logic                  done_now;
    drcu_state_e           state_reg;
    drcu_state_e           state_next;

    // refresh cycle outputs
    logic [PHYS_W-1:0]     addr_reg;
    logic                  hbe_reg;
    logic                  strobe_n_reg;

    // access decode
    logic                  acc_ok;
    logic                  wr_base;
    logic                  wr_interval;
    logic                  wr_enable;

    drcu_row_if            row_if ();

    drcu_row_lfsr u_row (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .row_if    (row_if)
    );

    // register port decode, gated by mode
    assign acc_ok      = enhanced_mode_i;
    assign wr_base     = reg_wr_i && acc_ok && (reg_addr_i == OFF_BASE);
    assign wr_interval = reg_wr_i && acc_ok && (reg_addr_i == OFF_INTERVAL);
    assign wr_enable   = reg_wr_i && acc_ok && (reg_addr_i == OFF_ENABLE_CNT);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            base_address_reg <= BASE_RST;
        end else if (wr_base) begin
            base_address_reg <= reg_wdata_i[BASE_MSB:BASE_LSB];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            interval_count_reg <= INTERVAL_RST;
        end else if (wr_interval) begin
            interval_count_reg <= reg_wdata_i[CNT_MSB:0];
        end
    end

    // only the enable bit is taken from the write
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            enable_reg <= 1'b0;
        end else if (wr_enable) begin
            enable_reg <= reg_wdata_i[EN_BIT];
        end
    end

    // down counter
    assign tick = enable_reg && (live_count_reg == CNT_ONE);

    always_comb begin
        live_count_next = live_count_reg;
        if (!enable_reg) begin
            live_count_next = CNT_ZERO;
        end else if (live_count_reg == CNT_ZERO) begin
            live_count_next = interval_count_reg;
        end else if (tick) begin
            live_count_next = interval_count_reg;
        end else begin
            live_count_next = live_count_reg - CNT_DEC;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            live_count_reg <= CNT_ZERO;
        end else begin
            live_count_reg <= live_count_next;
        end
    end

    // read data, valid the cycle after the strobe only
    always_comb begin
        rdata_next = RDATA_ZERO;
        if (reg_rd_i && acc_ok) begin
            case (reg_addr_i)
                OFF_BASE: begin
                    rdata_next[BASE_MSB:BASE_LSB] = base_address_reg;
                end
                OFF_INTERVAL: begin
                    rdata_next[CNT_MSB:0] = interval_count_reg;
                end
                OFF_ENABLE_CNT: begin
                    rdata_next[EN_BIT]    = enable_reg;
                    rdata_next[CNT_MSB:0] = enable_reg ? live_count_reg : CNT_ZERO;
                end
                default: begin
                    rdata_next = RDATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= RDATA_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // pending request, one deep; a new tick wins over the clear
    assign done_now = (state_reg == ST_RUN) && refresh_done_i;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pending_reg <= 1'b0;
        end else if (tick) begin
            pending_reg <= 1'b1;
        end else if (done_now) begin
            pending_reg <= 1'b0;
        end
    end

    assign refresh_req_o = pending_reg;
    assign row_if.step   = done_now;

    // bus arbitration
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (pending_reg) begin
                    state_next = ST_RUN;
                end else if (hold_req_i) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (pending_reg) begin
                    state_next = ST_RECLAIM;
                end else if (!hold_req_i) begin
                    state_next = ST_IDLE;
                end
            end
            ST_RECLAIM: begin
                if (!hold_req_i) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (refresh_done_i) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // grant only while no refresh is pending
    assign bus_hold_grant_o = (state_reg == ST_HOLD) && hold_req_i && !pending_reg;
    assign other_grant_o    = (state_reg == ST_IDLE) && other_req_i && !pending_reg && !hold_req_i;
    assign refresh_cycle_o  = (state_reg == ST_RUN);

    // refresh cycle address and byte marking
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            addr_reg <= {BASE_RST, FIX_ZERO_BITS, ROW_SEED, ADDR_A0_REFR};
        end else begin
            addr_reg <= {base_address_reg, FIX_ZERO_BITS, row_if.row, ADDR_A0_REFR};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hbe_reg      <= 1'b0;
            strobe_n_reg <= 1'b1;
        end else begin
            hbe_reg      <= BUS_16 && (state_next == ST_RUN);
            strobe_n_reg <= !(!BUS_16 && (state_next == ST_RUN));
        end
    end

    assign refresh_addr_o     = addr_reg;
    assign high_byte_enable_o = hbe_reg;
    assign refresh_strobe_n_o = strobe_n_reg;

    // checks
    sequence s_reach_one;
        enable_reg && (live_count_reg == CNT_ONE);
    endsequence

    sequence s_refresh_done;
        (state_reg == ST_RUN) && refresh_done_i && !tick;
    endsequence

    sequence s_done_then_hold;
        (s_refresh_done and hold_req_i) ##1 (hold_req_i && !pending_reg);
    endsequence

    AST_DISABLE_ZERO: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !enable_reg |=> (live_count_reg == CNT_ZERO))
        else $error("count not zero while disabled");

    AST_RELOAD_AT_ONE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_reach_one |=> (live_count_reg == $past(interval_count_reg)) && pending_reg)
        else $error("count did not reload or request at one");

    AST_DECREMENT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        enable_reg && (live_count_reg > CNT_ONE) |=> (live_count_reg == $past(live_count_reg) - CNT_DEC))
        else $error("count did not decrement");

    AST_REQ_STAYS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        pending_reg && !done_now |=> pending_reg)
        else $error("request dropped before refresh ran");

    AST_DONE_CLEARS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_refresh_done |=> !pending_reg && (row_if.row != $past(row_if.row)))
        else $error("refresh completion did not clear or step row");

    AST_ROW_STILL: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !done_now |=> $stable(row_if.row))
        else $error("row changed without refresh");

    AST_GRANT_DROP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        pending_reg |-> !bus_hold_grant_o && !other_grant_o)
        else $error("grant given while refresh pending");

    AST_WAIT_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == ST_RECLAIM) && hold_req_i |=> (state_reg != ST_RUN))
        else $error("refresh started under hold");

    AST_REGRANT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_done_then_hold |=> bus_hold_grant_o || !hold_req_i || pending_reg)
        else $error("hold not regranted after refresh");

    AST_ADDR_FORM: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        refresh_cycle_o |-> refresh_addr_o[0] && (refresh_addr_o[12:10] == FIX_ZERO_BITS)
            && (refresh_addr_o[19:13] == $past(base_address_reg)))
        else $error("refresh address malformed");

    AST_MARKING: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        refresh_cycle_o |-> (high_byte_enable_o == BUS_16) && (refresh_strobe_n_o == BUS_16))
        else $error("refresh cycle marking wrong");

    AST_MODE_GUARD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (reg_wr_i || reg_rd_i) && !enhanced_mode_i |=> $stable(enable_reg) && (reg_rdata_o == RDATA_ZERO))
        else $error("access acted outside enhanced mode");

    AST_READBACK: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        reg_rd_i && enhanced_mode_i && (reg_addr_i == OFF_ENABLE_CNT)
            |=> (reg_rdata_o[EN_BIT] == $past(enable_reg))
            && (reg_rdata_o[CNT_MSB:0] == ($past(enable_reg) ? $past(live_count_reg) : CNT_ZERO)))
        else $error("enable/count readback wrong");

endmodule

`default_nettype wire

/* drcu_far_model.sv */
`timescale 1ns/100ps
`default_nettype none

module drcu_far_model (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    // bus interface unit side
    input  wire logic       cycle_i,
    input  wire logic [4:0] dly_i,
    output logic            done_o,
    // external hold master side
    input  wire logic       want_i,
    input  wire logic       grant_i,
    output logic            hold_o
);
    logic [4:0] wait_reg;
    logic       had_grant_reg;
    logic       backoff_reg;
    logic       lost_grant;

    assign lost_grant = hold_o && had_grant_reg && !grant_i;

    // completion after a programmable stretch of the refresh read
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !cycle_i || done_o) begin
            wait_reg <= 5'h00;
            done_o   <= 1'b0;
        end else begin
            wait_reg <= wait_reg + 5'h01;
            done_o   <= (wait_reg >= dly_i);
        end
    end

    // hold master backs off when its grant is taken away
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hold_o        <= 1'b0;
            had_grant_reg <= 1'b0;
            backoff_reg   <= 1'b0;
        end else begin
            had_grant_reg <= grant_i && hold_o;
            if (lost_grant) begin
                backoff_reg <= 1'b1;
            end else if (cycle_i) begin
                backoff_reg <= 1'b0;
            end
            hold_o <= want_i && !backoff_reg && !lost_grant;
        end
    end
endmodule

`default_nettype wire

/* drcu_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) check_val(20'(got), 20'(exp))

module drcu_top_test;
    import drcu_pkg::*;
    logic        mclk_i          = 1'b0;
    logic        sys_rst_i       = 1'b1;
    logic [7:0]  reg_addr_i      = 8'h00;
    logic [15:0] reg_wdata_i     = 16'h0000;
    logic        reg_wr_i        = 1'b0;
    logic        reg_rd_i        = 1'b0;
    logic        enhanced_mode_i = 1'b1;
    logic        other_req_i     = 1'b0;
    logic        hold_want       = 1'b0;
    logic [4:0]  done_dly        = 5'h00;
    logic [15:0] reg_rdata_o;
    logic [19:0] refresh_addr_o;
    logic        refresh_req_o, refresh_cycle_o, refresh_done_i, high_byte_enable_o;
    logic        refresh_strobe_n_o, other_grant_o, hold_req_i, bus_hold_grant_o;
    logic [8:0]  row_exp         = ROW_SEED;
    logic [6:0]  base            = 7'h00;
    logic [8:0]  ival;
    logic [1:0]  mark8;
    int          seed            = 32'h867b;
    int          miscompares     = 0;
    int          comparisons     = 0;
    int          cycles          = 0;

    drcu_top dut (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .enhanced_mode_i, .refresh_req_o, .refresh_cycle_o, .refresh_done_i, .refresh_addr_o,
        .high_byte_enable_o, .refresh_strobe_n_o, .other_req_i, .other_grant_o, .hold_req_i, .bus_hold_grant_o);

    // 8-bit variant in lock step, only its cycle marking is watched
    drcu_top #(.BUS_16(1'b0)) dut8 (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o(), .enhanced_mode_i, .refresh_req_o(), .refresh_cycle_o(), .refresh_done_i,
        .refresh_addr_o(), .high_byte_enable_o(mark8[1]), .refresh_strobe_n_o(mark8[0]), .other_req_i,
        .other_grant_o(), .hold_req_i, .bus_hold_grant_o());

    drcu_far_model far (.mclk_i, .sys_rst_i, .cycle_i(refresh_cycle_o), .dly_i(done_dly),
        .done_o(refresh_done_i), .want_i(hold_want), .grant_i(bus_hold_grant_o), .hold_o(hold_req_i));

    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic check_val(input logic [19:0] got, input logic [19:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask

    // one register access; read data are settled on return
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
        reg_wr_i    <= w;
        reg_rd_i    <= r;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
        reg_rd_i    <= 1'b0;
        #1;
    endtask

    function automatic logic [8:0] row_step(input logic [8:0] r);
        return {r[7:0], r[LFSR_TAP_A] ^ r[LFSR_TAP_B]};
    endfunction

    always @(posedge mclk_i) begin
        other_req_i <= 1'($random(seed));
    end

    always @(negedge mclk_i) begin
        if (!sys_rst_i) begin
            `CHK({high_byte_enable_o, refresh_strobe_n_o}, {refresh_cycle_o, 1'b1});
            `CHK(mark8, {1'b0, !refresh_cycle_o});
            if (refresh_cycle_o) begin
                `CHK(refresh_addr_o, {base, 3'h0, row_exp, 1'b1});
                `CHK(refresh_req_o, 1'b1);
                if (refresh_done_i) row_exp = row_step(row_exp);
            end
            if (bus_hold_grant_o && (refresh_req_o || refresh_cycle_o)) `CHK(1'b1, 1'b0);
            if (other_grant_o && (refresh_req_o || bus_hold_grant_o)) `CHK(1'b1, 1'b0);
        end
        cycles++;
        if (cycles > 5000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        int n;
        repeat (8) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        #1;
        `CHK(refresh_addr_o, 20'h00003);
        acc(1'b0, 1'b1, OFF_ENABLE_CNT, 16'h0000);
        `CHK(reg_rdata_o, 16'h0000);
        base = 7'($random(seed));
        ival = 9'd18 + 9'($random(seed) & 15);
        acc(1'b1, 1'b0, OFF_BASE, {base, 9'($random(seed))});
        acc(1'b1, 1'b0, OFF_INTERVAL, {7'h00, ival});
        acc(1'b0, 1'b1, OFF_BASE, 16'h0000);
        `CHK(reg_rdata_o, {base, 9'h000});
        acc(1'b1, 1'b0, 8'he6, 16'hffff);
        acc(1'b0, 1'b1, 8'he6, 16'h0000);
        `CHK(reg_rdata_o, 16'h0000);
        enhanced_mode_i <= 1'b0;
        acc(1'b1, 1'b0, OFF_INTERVAL, 16'h0001);
        acc(1'b0, 1'b1, OFF_INTERVAL, 16'h0000);
        `CHK(reg_rdata_o, 16'h0000);
        enhanced_mode_i <= 1'b1;
        acc(1'b0, 1'b1, OFF_INTERVAL, 16'h0000);
        `CHK(reg_rdata_o, {7'h00, ival});
        acc(1'b1, 1'b0, OFF_ENABLE_CNT, 16'h7fff);
        acc(1'b0, 1'b1, OFF_ENABLE_CNT, 16'h0000);
        `CHK(reg_rdata_o, 16'h0000);
        acc(1'b1, 1'b0, OFF_ENABLE_CNT, 16'h8000 | 16'($random(seed)));
        acc(1'b0, 1'b1, OFF_ENABLE_CNT, 16'h0000);
        `CHK(reg_rdata_o, 16'h8000);
        acc(1'b0, 1'b1, OFF_ENABLE_CNT, 16'h0000);
        `CHK(reg_rdata_o, 16'h8000 | ival);
        acc(1'b0, 1'b1, OFF_ENABLE_CNT, 16'h0000);
        `CHK(reg_rdata_o, 16'h8000 | (ival - 9'd1));
        acc(1'b1, 1'b0, OFF_ENABLE_CNT, 16'hffff);
        acc(1'b0, 1'b1, OFF_ENABLE_CNT, 16'h0000);
        `CHK(reg_rdata_o, 16'h8000 | (ival - 9'd3));
        // spacing of two requests with a prompt bus unit
        for (n = 0; n < 100 && !refresh_req_o; n++) tick();
        for (n = 0; n < 100 && refresh_req_o; n++) tick();
        for (n = 0; n < 100 && !refresh_req_o; n++) tick();
        for (n = 0; n < 100 && refresh_req_o; n++) tick();
        for (; n < 100 && !refresh_req_o; n++) tick();
        `CHK(n, ival);
        // slow service loses ticks but never rows
        done_dly <= 5'd31;
        repeat (150) tick();
        repeat (3) begin
            done_dly  <= 5'($random(seed) & 3);
            hold_want <= 1'b1;
            for (n = 0; n < 100 && !bus_hold_grant_o; n++) tick();
            `CHK(bus_hold_grant_o, 1'b1);
            for (n = 0; n < 100 && bus_hold_grant_o; n++) tick();
            `CHK({refresh_req_o, hold_req_i, refresh_cycle_o}, 3'b110);
            for (n = 0; n < 20 && !refresh_cycle_o; n++) tick();
            `CHK(refresh_cycle_o, 1'b1);
            for (n = 0; n < 20 && !bus_hold_grant_o; n++) tick();
            `CHK(bus_hold_grant_o, 1'b1);
        end
        hold_want <= 1'b0;
        acc(1'b1, 1'b0, OFF_ENABLE_CNT, 16'($random(seed)) & 16'h7fff);
        acc(1'b0, 1'b1, OFF_ENABLE_CNT, 16'h0000);
        `CHK(reg_rdata_o, 16'h0000);
        repeat (60) tick();
        `CHK(refresh_req_o, 1'b0);
        acc(1'b1, 1'b0, OFF_ENABLE_CNT, 16'h8000);
        sys_rst_i <= 1'b1;
        tick();
        tick();
        sys_rst_i <= 1'b0;
        base    = 7'h00;
        row_exp = ROW_SEED;
        acc(1'b0, 1'b1, OFF_ENABLE_CNT, 16'h0000);
        `CHK(reg_rdata_o, 16'h0000);
        repeat (40) tick();
        `CHK(refresh_req_o, 1'b0);
        final_report();
    end
endmodule

`default_nettype wire
